// [sldrv_consts.svh]
// Overview of operation
// - Shift one bit in per rising clock
// - New bits enter only from serial input
// - Last stage driven out for cascading
// - Sixteen channels, each from own latch
// - Strobe high copies stages into latches
// - Latches transparent while high, hold when low
// - Blanking high switches all channels off
// - Blanking never changes latch contents
// - Blanking low drives channels from latches
`ifndef SLDRV_CONSTS_SVH
`define SLDRV_CONSTS_SVH

// ----------------------------------------
// Widths and reset values
// ----------------------------------------
`define SLDRV_CHANNELS 16
`define SLDRV_MSB 15
`define SLDRV_ZERO16 16'h0000
`define SLDRV_ALL_OFF 16'h0000
`define SLDRV_PIN_RESET 4'h0

`endif

// [sldrv_host.sv]
`timescale 1ns/10ps
// ----------------------------------------
// Host model driving the serial pins
// ----------------------------------------
module sldrv_host
(
  // System
  input wire logic clk,
  // Pins to device
  output logic serial_in,
  output logic shift_clk,
  output logic load_strobe,
  output logic blank_n
);
  // Idle pins, channels enabled
  initial
  begin
    serial_in = 1'h0;
    shift_clk = 1'h0;
    load_strobe = 1'h0;
    blank_n = 1'h0;
  end
  // Wait n falling edges
  task automatic hold(input int n);
    repeat (n) @(negedge clk);
  endtask : hold
  // Phases of 4 clocks beat the 2-clock synchroniser minimum
  task automatic send_bit(input logic b);
    serial_in = b;
    hold(4);
    shift_clk = 1'h1;
    hold(4);
    shift_clk = 1'h0;
    hold(4);
  endtask : send_bit
  // Highest bit first, so it ends in stage 15
  task automatic send_word(input logic [15:0] w);
    for (int i = 15; i >= 0; i--)
      send_bit(w[i]);
  endtask : send_word
  // Strobe and blanking levels, then settle
  task automatic set_pins(input logic s, input logic b);
    load_strobe = s;
    blank_n = b;
    hold(6);
  endtask : set_pins
endmodule : sldrv_host

// [sldrv_pkg.sv]
`include "sldrv_consts.svh"
package sldrv_pkg;
  // Channel word type
  typedef logic [`SLDRV_MSB:0] sldrv_word_t;
  // Pin edge detector states
  typedef enum logic [0:0] {SLDRV_CLK_LOW, SLDRV_CLK_HIGH} sldrv_edge_t;
endpackage : sldrv_pkg

// [sldrv_sync.sv]
`timescale 1ns/10ps
`include "sldrv_consts.svh"
// ----------------------------------------
// Two-stage synchroniser, four pins wide
// ----------------------------------------
module sldrv_sync
(
  // System
  input wire logic clk,
  input wire logic rst,
  // Pin side
  input wire logic [3:0] pin_in,
  // Logic side
  output logic [3:0] pin_sync
);
  logic [3:0] meta_reg;
  logic [3:0] meta_next;
  logic [3:0] sync_reg;
  logic [3:0] sync_next;

  // First stage only feeds the second
  always_comb
  begin
    meta_next = pin_in;
    sync_next = meta_reg;
  end

  // Register both stages
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_reg <= `SLDRV_PIN_RESET;
      sync_reg <= `SLDRV_PIN_RESET;
    end
    else
    begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign pin_sync = sync_reg;
endmodule : sldrv_sync

// [sldrv_top.sv]
`timescale 1ns/10ps
`include "sldrv_consts.svh"
// ----------------------------------------
// Serial latched sink driver logic
// ----------------------------------------
module sldrv_top
  import sldrv_pkg::*;
(
  // System
  input wire logic clk,
  input wire logic rst,
  // Serial pins from host
  input wire logic serial_in,
  input wire logic shift_clk,
  input wire logic load_strobe,
  input wire logic blank_n,
  // Cascade output
  output logic serial_out,
  // Channel drive, one means sinking
  output logic [`SLDRV_MSB:0] sink_channel
);
  // ----------------------------------------
  // Pin synchronisation
  // ----------------------------------------
  // Order: serial, clock, strobe, blanking
  logic [3:0] pins_s;

  // Pins are async to clk, so all pass two flops
  // Serial data rides the same flops as the shift clock, so the pair
  // keeps its order; the host must hold data a few clks round the rise
  sldrv_sync u_sync
  (
    .clk(clk),
    .rst(rst),
    .pin_in({serial_in, shift_clk, load_strobe, blank_n}),
    .pin_sync(pins_s)
  );

  logic din_s;
  logic sck_s;
  logic strobe_s;
  logic blank_s;
  assign din_s = pins_s[3];
  assign sck_s = pins_s[2];
  assign strobe_s = pins_s[1];
  assign blank_s = pins_s[0];

  // ----------------------------------------
  // State
  // ----------------------------------------
  sldrv_edge_t edge_reg;         // Last seen shift clock level
  sldrv_edge_t edge_next;
  sldrv_word_t shift_reg;        // Shift stages
  sldrv_word_t shift_next;
  sldrv_word_t latch_reg;        // Channel latches
  sldrv_word_t latch_next;
  sldrv_word_t drive_reg;        // Registered channel drive
  sldrv_word_t drive_next;
  logic sout_reg;                // Registered cascade bit
  logic sout_next;
  logic rise;

  // Channel drive from latch and blanking
  function automatic sldrv_word_t sldrv_drive(input sldrv_word_t lat, input logic blk);
    // Blanked gives all off, else latch one sinks
    sldrv_drive = blk ? `SLDRV_ALL_OFF : lat;
  endfunction : sldrv_drive

  // ----------------------------------------
  // Shift clock edge detect
  // ----------------------------------------
  // Detector state doubles as the last seen level of the pin
  // Sync adds two cycles of latency, which limits the shift rate
  always_comb
  begin
    rise = 1'h0;
    edge_next = edge_reg;
    case (edge_reg)
      SLDRV_CLK_LOW:
      begin
        // Rise seen: one shift, then wait for the low phase
        if (sck_s)
        begin
          rise = 1'h1;
          edge_next = SLDRV_CLK_HIGH;
        end
      end
      SLDRV_CLK_HIGH:
      begin
        // Re-arm only once the pin is low again
        if (!sck_s)
          edge_next = SLDRV_CLK_LOW;
      end
      default:
        edge_next = SLDRV_CLK_LOW;
    endcase
  end

  // Register the detector only
  always_ff @(posedge clk)
  begin
    if (rst)
      edge_reg <= SLDRV_CLK_LOW; // Pin idles low, so no false rise
    else
      edge_reg <= edge_next;
  end

  // ----------------------------------------
  // Shift register and cascade bit
  // ----------------------------------------
  // First bit in ends in the top stage after sixteen rises
  // Shift toward the top stage; only entry is serial input
  always_comb
  begin
    shift_next = shift_reg;
    if (rise)
      shift_next = {shift_reg[`SLDRV_MSB-1:0], din_s};
    // Cascade bit is the top stage, one clk behind it
    sout_next = shift_reg[`SLDRV_MSB];
  end

  // Register stages and cascade bit
  // Power-on stages chosen zero, so the cascade starts low
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      shift_reg <= `SLDRV_ZERO16;
      sout_reg <= 1'h0;
    end
    else
    begin
      shift_reg <= shift_next;
      sout_reg <= sout_next;
    end
  end

  // ----------------------------------------
  // Channel latches
  // ----------------------------------------
  // Transparent while strobe high; built from flops, so it lags
  // the stages by one clk rather than being a true latch
  always_comb
  begin
    latch_next = latch_reg;
    if (strobe_s)
      latch_next = shift_reg;
  end

  // Register latches; blanking is no input here, so it never disturbs them
  always_ff @(posedge clk)
  begin
    if (rst)
      latch_reg <= `SLDRV_ZERO16; // Power-on contents chosen all off
    else
      latch_reg <= latch_next;
  end

  // ----------------------------------------
  // Channel drive
  // ----------------------------------------
  // Blanked gives all off, else each latch bit drives its own channel
  // Drive reads the latches but never writes them back
  always_comb
  begin
    drive_next = sldrv_drive(latch_reg, blank_s);
  end

  // Register the drive so the outputs come straight from flops
  always_ff @(posedge clk)
  begin
    if (rst)
      drive_reg <= `SLDRV_ALL_OFF;
    else
      drive_reg <= drive_next;
  end

  // Outputs
  assign serial_out = sout_reg;
  assign sink_channel = drive_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  shift_step_a: assert property (@(posedge clk) disable iff (rst)
    rise |=> shift_reg == {$past(shift_reg[`SLDRV_MSB-1:0]), $past(din_s)})
    else $error("shift did not advance");
  shift_hold_a: assert property (@(posedge clk) disable iff (rst)
    !rise |=> $stable(shift_reg))
    else $error("shift changed without edge");
  cascade_out_a: assert property (@(posedge clk) disable iff (rst)
    ##1 serial_out == $past(shift_reg[`SLDRV_MSB]))
    else $error("serial out not top stage");
  latch_load_a: assert property (@(posedge clk) disable iff (rst)
    strobe_s |=> latch_reg == $past(shift_reg))
    else $error("latch not transparent");
  latch_keep_a: assert property (@(posedge clk) disable iff (rst)
    !strobe_s |=> $stable(latch_reg))
    else $error("latch changed while closed");
  blank_off_a: assert property (@(posedge clk) disable iff (rst)
    blank_s |=> sink_channel == `SLDRV_ALL_OFF)
    else $error("channels on while blanked");
  blank_keep_a: assert property (@(posedge clk) disable iff (rst)
    (!strobe_s && $changed(blank_s)) |=> $stable(latch_reg))
    else $error("blanking disturbed latches");
  drive_follow_a: assert property (@(posedge clk) disable iff (rst)
    !blank_s |=> sink_channel == $past(latch_reg))
    else $error("channel drive not from latch");
  first_bit_a: assert property (@(posedge clk) disable iff (rst)
    (rise ##1 (!rise)[*2]) |-> shift_reg[0] == $past(din_s, 2))
    else $error("first stage wrong");
  // Checks watch the synchronised pins, since that is what the logic acts on
  // One shift per rise, set top latch bit sinks and clear bit 0 stays off, cascade moves on shifts
  edge_once_a: assert property (@(posedge clk) disable iff (rst)
    rise |=> !rise)
    else $error("two shifts for one clock rise");
  sink_on_a: assert property (@(posedge clk) disable iff (rst)
    (!blank_s && latch_reg[`SLDRV_MSB]) |=> sink_channel[`SLDRV_MSB])
    else $error("set latch bit not sinking");
  sink_off_a: assert property (@(posedge clk) disable iff (rst)
    (!blank_s && !latch_reg[0]) |=> !sink_channel[0])
    else $error("clear latch bit still sinking");
  sout_change_a: assert property (@(posedge clk) disable iff (rst)
    $changed(serial_out) |-> $past(rise, 2))
    else $error("serial out moved without shift");
endmodule : sldrv_top

// [sldrv_top_tb_top.sv]
`timescale 1ns/10ps
module sldrv_top_tb_top
  import sldrv_pkg::*;
;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic serial_in, shift_clk, load_strobe, blank_n, serial_out;
  sldrv_word_t sink_channel;
  int miscompares = 0;
  int n_checks = 0;
  int cycles = 0;
  always #12.5 clk = ~clk;
  sldrv_host i_sldrv_host (.clk(clk), .serial_in(serial_in), .shift_clk(shift_clk),
    .load_strobe(load_strobe), .blank_n(blank_n));
  sldrv_top i_sldrv_top (.clk(clk), .rst(rst), .serial_in(serial_in),
    .shift_clk(shift_clk), .load_strobe(load_strobe), .blank_n(blank_n),
    .serial_out(serial_out), .sink_channel(sink_channel));
  task automatic check(input string name, input sldrv_word_t seen, input sldrv_word_t exp);
    n_checks++;
    if (seen !== exp)
    begin
      $display("BAD %s expected %h seen %h", name, exp, seen);
      miscompares++;
    end
  endtask : check
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : finish_test
  // Cut a hang short
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      miscompares++;
      finish_test();
    end
  end
  // Shift a word in, latches must wait for the strobe
  task automatic test_load;
    i_sldrv_host.send_word(16'hA5C3);
    check("sink", sink_channel, 16'h0000);
    check("sout", {15'h0000, serial_out}, 16'h0001);
    i_sldrv_host.set_pins(1'h1, 1'h0);
    i_sldrv_host.set_pins(1'h0, 1'h0);
    check("sink", sink_channel, 16'hA5C3);
    $display("test_load done");
  endtask : test_load
  // Held latches survive shifting and blanking
  task automatic test_hold_blank;
    i_sldrv_host.send_word(16'h3C5A);
    check("sink", sink_channel, 16'hA5C3);
    check("sout", {15'h0000, serial_out}, 16'h0000);
    i_sldrv_host.set_pins(1'h0, 1'h1);
    check("sink", sink_channel, 16'h0000);
    i_sldrv_host.set_pins(1'h0, 1'h0);
    check("sink", sink_channel, 16'hA5C3);
    i_sldrv_host.set_pins(1'h1, 1'h0);
    check("sink", sink_channel, 16'h3C5A);
    $display("test_hold_blank done");
  endtask : test_hold_blank
  // Open latch follows each shift, closed one holds
  task automatic test_transparent;
    i_sldrv_host.set_pins(1'h1, 1'h1);
    i_sldrv_host.send_bit(1'h1);
    check("sink", sink_channel, 16'h0000);
    i_sldrv_host.set_pins(1'h1, 1'h0);
    check("sink", sink_channel, 16'h78B5);
    i_sldrv_host.set_pins(1'h0, 1'h0);
    i_sldrv_host.send_bit(1'h0);
    check("sink", sink_channel, 16'h78B5);
    $display("test_transparent done");
  endtask : test_transparent
  // Mid-run reset clears stages, latches and outputs
  task automatic test_reset;
    check("sout", {15'h0000, serial_out}, 16'h0001);
    rst = 1'h1;
    i_sldrv_host.hold(4);
    rst = 1'h0;
    i_sldrv_host.hold(3);
    check("sink", sink_channel, 16'h0000);
    check("sout", {15'h0000, serial_out}, 16'h0000);
    $display("test_reset done");
  endtask : test_reset
  initial
  begin
    repeat (20) @(negedge clk);
    rst = 1'h0;
    repeat (3) @(negedge clk);
    test_load();
    test_hold_blank();
    test_transparent();
    test_reset();
    finish_test();
  end
endmodule : sldrv_top_tb_top
